// >>> design/tcc_pkg.sv
`default_nettype none
package tcc_pkg;

  // Register port geometry.
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NCAP   = 4;
  localparam int unsigned NCMP   = 3;

  // Register offsets on the plain register port.
  localparam logic [4:0] OFS_TLO   = 5'h00;
  localparam logic [4:0] OFS_THI   = 5'h01;
  localparam logic [4:0] OFS_CTRL  = 5'h02;
  localparam logic [4:0] OFS_FLAG  = 5'h03;
  localparam logic [4:0] OFS_CEDGE = 5'h04;
  localparam logic [4:0] OFS_SETEN = 5'h05;
  localparam logic [4:0] OFS_RSTEN = 5'h06;
  localparam logic [4:0] OFS_IEN   = 5'h07;
  localparam logic [4:0] OFS_CAP0  = 5'h08;
  localparam logic [4:0] OFS_CMP0  = 5'h10;
  localparam logic [4:0] OFS_P4    = 5'h16;
  localparam logic [4:0] OFS_LAST  = 5'h1f;

  // Field positions.
  localparam int unsigned IEN_BIT      = 7;
  localparam int unsigned FLG_WORD     = 7;
  localparam int unsigned FLG_CMP_LO   = 4;
  localparam int unsigned FLG_CAP_LO   = 0;
  localparam int unsigned TOG_LO       = 6;
  localparam int unsigned TOG_HI       = 7;

  // Reset values and masks.
  localparam logic [7:0]  BYTE_RST   = 8'h00;
  localparam logic [15:0] WORD_RST   = 16'h0000;
  localparam logic [7:0]  P4_SR_MASK = 8'h3f;
  localparam logic [1:0]  TOG_RST    = 2'h3;
  localparam logic [7:0]  BYTE_MAX   = 8'hff;
  localparam logic [15:0] WORD_MAX   = 16'hffff;
  localparam logic [2:0]  PRE_ONE    = 3'h1;

  // Clock source encodings.
  localparam logic [1:0] SRC_OFF = 2'h0;
  localparam logic [1:0] SRC_OSC = 2'h1;
  localparam logic [1:0] SRC_EXT = 2'h2;

  // Six state phases of one machine cycle.
  typedef enum logic [2:0] {
    PH_S1 = 3'b000,
    PH_S2 = 3'b001,
    PH_S3 = 3'b010,
    PH_S4 = 3'b011,
    PH_S5 = 3'b100,
    PH_S6 = 3'b101
  } tcc_phase_t;

  // Timer control register layout.
  typedef struct packed {
    logic       word_sel;
    logic       byte_sel;
    logic       ext_rst_en;
    logic       byte_flag;
    logic [1:0] presc;
    logic [1:0] src;
  } tcc_ctrl_t;

endpackage
`default_nettype wire

// >>> design/tcc_timer_capture_compare.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RULE1 - 16-bit timer in two bytes, clocked via prescaler from cycle tick, external pin, or off.
// RULE2 - Counter mode advances the prescaler on each external rising edge, one per cycle.
// RULE3 - External count sampled twice per cycle; low then high sample is an edge.
// RULE4 - Edge seen at first sample counts next cycle, otherwise one cycle later.
// RULE5 - Prescaler divides by 1, 2, 4 or 8; cleared on change or timer reset.
// RULE6 - Timer readable while running, no shadow latch, and not writable by software.
// RULE7 - Chip reset clears timer; enabled external reset rising edge clears timer and prescaler.
// RULE8 - Byte and word overflow flags set one cycle late; word overflow sets both.
// RULE9 - Byte overflow requests interrupt only with timer enable and byte select set.
// RULE10 - Word overflow requests interrupt only with timer enable and word select set.
// RULE11 - Both overflow sources share one interrupt output; software tests the flags.
// RULE12 - Hardware never clears interrupt flags; software clears each flag itself.
// RULE13 - Idle mode holds timer and prescaler in reset.
// RULE14 - Four capture registers load the timer and set their own flags.
// RULE15 - Each capture input triggers on rising, falling or both edges.
// RULE16 - Capture inputs sampled at first phase; timer captured at end of that cycle.
// RULE17 - New timer value compared with three registers; flag set end of next cycle.
// RULE18 - First compare match sets port bits 0-5 enabled in the set-enable register.
// RULE19 - Second compare match clears port bits 0-5 enabled in reset/toggle enable.
// RULE20 - Compare changes beat software writes; set with reset leaves the bit reset.
// RULE21 - Interrupt is OR of flags gated by selects, qualified by timer enable.
module tcc_timer_capture_compare
  import tcc_pkg::*;
(
  input  wire logic              mclk,          // Oscillator clock.
  input  wire logic              resetn,        // Chip reset, active low.
  input  wire logic              ce,            // Clock enable, freezes all state when low.
  input  wire logic              idle,          // Processor idle mode.
  input  wire logic              ext_count_in,  // External count input.
  input  wire logic              ext_reset_in,  // External timer reset input.
  input  wire logic [NCAP-1:0]   cap_in,        // Capture inputs.
  input  wire logic [ADDR_W-1:0] reg_addr,      // Register address.
  input  wire logic [DATA_W-1:0] reg_wdata,     // Register write data.
  input  wire logic              reg_wr,        // Write strobe.
  input  wire logic              reg_rd,        // Read strobe.
  output logic      [DATA_W-1:0] reg_rdata,     // Read data, one cycle after the strobe.
  output logic                   timer_irq,     // Shared overflow interrupt request.
  output logic      [7:0]        port4          // Port 4 output latch.
);

  tcc_phase_t  phase_q;
  tcc_phase_t  phase_d;
  tcc_ctrl_t   ctrl_q;
  tcc_ctrl_t   ctrl_d;
  logic [15:0] timer_q;
  logic [15:0] timer_nx;
  logic [2:0]  pre_q;
  logic [2:0]  pre_lim;
  logic [7:0]  flag_q;
  logic [7:0]  flag_d;
  logic [7:0]  cedge_q;
  logic [5:0]  seten_q;
  logic [7:0]  rsten_q;
  logic        ien_q;
  logic [7:0]  p4_q;
  logic [7:0]  p4_d;
  logic [1:0]  tog_q;
  logic [1:0]  tog_d;
  logic [15:0] cap_q [NCAP];
  logic [15:0] cmp_q [NCMP];
  logic [7:0]  view [32];
  logic [NCAP-1:0] csmp_q;
  logic [NCAP-1:0] chit_q;
  logic [NCAP-1:0] cap_set;
  logic [NCMP-1:0] match_q;
  logic        tc_smp_q;
  logic        tc_early_q;
  logic        tc_late_q;
  logic        inc1_q;
  logic        inc2_q;
  logic        rt_q;
  logic        ovb_q;
  logic        ovw_q;
  logic [7:0]  rdata_q;
  logic        irq_q;

  // Phase sequencing and event decode.
  wire cyc_end   = (phase_q == PH_S6);
  wire smp_early = (phase_q == PH_S2);
  wire smp_late  = (phase_q == PH_S5);
  wire smp_cap   = (phase_q == PH_S1);
  wire tc_edge   = ext_count_in & ~tc_smp_q;                                   // [RULE3]
  wire rt_edge   = ext_reset_in & ~rt_q;
  wire timer_clr = idle | (ctrl_q.ext_rst_en & rt_edge);                       // [RULE7] [RULE13]

  // Register write decode.
  wire wr_ctrl  = reg_wr & (reg_addr == OFS_CTRL);
  wire wr_flag  = reg_wr & (reg_addr == OFS_FLAG);
  wire wr_cedge = reg_wr & (reg_addr == OFS_CEDGE);
  wire wr_seten = reg_wr & (reg_addr == OFS_SETEN);
  wire wr_rsten = reg_wr & (reg_addr == OFS_RSTEN);
  wire wr_ien   = reg_wr & (reg_addr == OFS_IEN);
  wire wr_p4    = reg_wr & (reg_addr == OFS_P4);

  // Source tick, prescaler and increment.
  wire src_tick = cyc_end & ((ctrl_q.src == SRC_OSC) | ((ctrl_q.src == SRC_EXT) & inc1_q)); // [RULE1] [RULE2]
  wire pre_chg  = wr_ctrl & (reg_wdata[3:0] != {ctrl_q.presc, ctrl_q.src});
  wire pre_clr  = timer_clr | pre_chg;                                         // [RULE5]
  wire pre_hit  = src_tick & (pre_q == pre_lim);
  wire tmr_inc  = pre_hit & ~pre_clr;
  assign pre_lim  = 3'((PRE_ONE << ctrl_q.presc) - PRE_ONE);                   // [RULE5]
  assign timer_nx = timer_q + 16'h0001;

  // Overflow and interrupt terms.
  wire ov_byte = tmr_inc & (timer_q[7:0] == BYTE_MAX);
  wire ov_word = tmr_inc & (timer_q == WORD_MAX);
  wire irq_d   = ien_q & ((flag_q[FLG_WORD] & ctrl_q.word_sel) |             // [RULE10] [RULE21]
                          (ctrl_q.byte_flag & ctrl_q.byte_sel));               // [RULE9] [RULE11]
  wire act_set = cyc_end & match_q[0];
  wire act_rst = cyc_end & match_q[1];
  wire act_tog = cyc_end & match_q[2];

  // Phase counter runs freely; all phase timing hangs off it.
  always_comb begin
    case (phase_q)
      PH_S1:   phase_d = PH_S2;
      PH_S2:   phase_d = PH_S3;
      PH_S3:   phase_d = PH_S4;
      PH_S4:   phase_d = PH_S5;
      PH_S5:   phase_d = PH_S6;
      PH_S6:   phase_d = PH_S1;
      default: phase_d = PH_S1;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      phase_q <= PH_S1;
    end else if (ce) begin
      phase_q <= phase_d;
    end
  end

  // External count sampling; an early edge counts next cycle, a late one a cycle after.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tc_smp_q   <= 1'b0;
      tc_early_q <= 1'b0;
      tc_late_q  <= 1'b0;
      inc1_q     <= 1'b0;
      inc2_q     <= 1'b0;
    end else if (ce) begin
      if (smp_early | smp_late) begin
        tc_smp_q <= ext_count_in;                                              // [RULE3]
      end
      if (smp_early & tc_edge) begin
        tc_early_q <= 1'b1;
      end
      if (smp_late & tc_edge) begin
        tc_late_q <= 1'b1;
      end
      if (cyc_end) begin
        inc1_q     <= tc_early_q | inc2_q;                                     // [RULE4] [RULE2]
        inc2_q     <= tc_late_q;                                               // [RULE4]
        tc_early_q <= 1'b0;
        tc_late_q  <= 1'b0;
      end
    end
  end

  // Timer and prescaler; software has no write path to the count.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      timer_q <= WORD_RST;                                                     // [RULE7]
      pre_q   <= 3'h0;
      rt_q    <= 1'b0;
    end else if (ce) begin
      rt_q <= ext_reset_in;
      if (pre_clr) begin
        pre_q <= 3'h0;                                                         // [RULE5] [RULE13]
      end else if (src_tick) begin
        pre_q <= pre_hit ? 3'h0 : 3'(pre_q + PRE_ONE);
      end
      if (timer_clr) begin
        timer_q <= WORD_RST;                                                   // [RULE7] [RULE13]
      end else if (tmr_inc) begin
        timer_q <= timer_nx;                                                   // [RULE1] [RULE6]
      end
    end
  end

  // Overflow and match pipeline: events latch at the increment, act one cycle later.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ovb_q   <= 1'b0;
      ovw_q   <= 1'b0;
      match_q <= '0;
    end else if (ce) begin
      if (cyc_end) begin
        ovb_q   <= ov_byte;                                                    // [RULE8]
        ovw_q   <= ov_word;
        match_q <= '0;
        for (int i = 0; i < NCMP; i++) begin
          match_q[i] <= tmr_inc & (timer_nx == cmp_q[i]);                      // [RULE17]
        end
      end
    end
  end

  // Capture channels: sample at the first phase, load at cycle end.
  for (genvar c = 0; c < NCAP; c++) begin : g_cap
    wire rise = cap_in[c] & ~csmp_q[c];
    wire fall = ~cap_in[c] & csmp_q[c];
    wire hit  = (rise & cedge_q[2*c]) | (fall & cedge_q[2*c+1]);             // [RULE15]
    assign cap_set[c] = cyc_end & chit_q[c];
    always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
        csmp_q[c] <= 1'b0;
        chit_q[c] <= 1'b0;
        cap_q[c]  <= WORD_RST;
      end else if (ce) begin
        if (smp_cap) begin
          csmp_q[c] <= cap_in[c];                                              // [RULE16]
          chit_q[c] <= hit;
        end else if (cyc_end) begin
          chit_q[c] <= 1'b0;
        end
        if (cap_set[c]) begin
          cap_q[c] <= timer_q;                                                 // [RULE14] [RULE16]
        end
      end
    end
    assign view[OFS_CAP0 + 5'(2*c)]     = cap_q[c][7:0];
    assign view[OFS_CAP0 + 5'(2*c + 1)] = cap_q[c][15:8];
  end

  // Compare registers are plain byte-wide writable words.
  for (genvar m = 0; m < NCMP; m++) begin : g_cmp
    wire wr_lo = reg_wr & (reg_addr == OFS_CMP0 + 5'(2*m));
    wire wr_hi = reg_wr & (reg_addr == OFS_CMP0 + 5'(2*m + 1));
    always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
        cmp_q[m] <= WORD_RST;
      end else if (ce) begin
        if (wr_lo) begin
          cmp_q[m][7:0] <= reg_wdata;
        end
        if (wr_hi) begin
          cmp_q[m][15:8] <= reg_wdata;
        end
      end
    end
    assign view[OFS_CMP0 + 5'(2*m)]     = cmp_q[m][7:0];
    assign view[OFS_CMP0 + 5'(2*m + 1)] = cmp_q[m][15:8];
  end

  // Flag updates: hardware sets are ORed after the software value, so a set wins.
  always_comb begin
    ctrl_d           = wr_ctrl ? tcc_ctrl_t'(reg_wdata) : ctrl_q;
    ctrl_d.byte_flag = ctrl_d.byte_flag | (cyc_end & ovb_q);                   // [RULE8] [RULE12]
    flag_d           = wr_flag ? reg_wdata : flag_q;                           // [RULE12]
    flag_d[FLG_WORD] = flag_d[FLG_WORD] | (cyc_end & ovw_q);                   // [RULE8] [RULE10]
    for (int i = 0; i < NCMP; i++) begin
      flag_d[FLG_CMP_LO + i] = flag_d[FLG_CMP_LO + i] | (cyc_end & match_q[i]); // [RULE17]
    end
    for (int i = 0; i < NCAP; i++) begin
      flag_d[FLG_CAP_LO + i] = flag_d[FLG_CAP_LO + i] | cap_set[i];           // [RULE14]
    end
  end

  // Port 4: software value first, then compare set, then compare reset so reset wins.
  always_comb begin
    p4_d  = wr_p4 ? reg_wdata : p4_q;                                          // [RULE20]
    tog_d = tog_q;
    if (act_set) begin
      p4_d = p4_d | ({2'b00, seten_q} & P4_SR_MASK);                           // [RULE18]
    end
    if (act_rst) begin
      p4_d = p4_d & ~(rsten_q & P4_SR_MASK);                                   // [RULE19] [RULE20]
    end
    if (act_tog & rsten_q[TOG_LO]) begin
      p4_d[TOG_LO] = tog_q[0];
      tog_d[0]     = ~tog_q[0];
    end
    if (act_tog & rsten_q[TOG_HI]) begin
      p4_d[TOG_HI] = tog_q[1];
      tog_d[1]     = ~tog_q[1];
    end
  end

  // Software-visible control registers.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q  <= tcc_ctrl_t'(BYTE_RST);
      flag_q  <= BYTE_RST;
      cedge_q <= BYTE_RST;
      seten_q <= 6'h00;
      rsten_q <= BYTE_RST;
      ien_q   <= 1'b0;
      p4_q    <= BYTE_RST;
      tog_q   <= TOG_RST;
    end else if (ce) begin
      ctrl_q <= ctrl_d;
      flag_q <= flag_d;
      p4_q   <= p4_d;
      tog_q  <= tog_d;
      if (wr_cedge) begin
        cedge_q <= reg_wdata;
      end
      if (wr_seten) begin
        seten_q <= reg_wdata[5:0];
      end
      if (wr_rsten) begin
        rsten_q <= reg_wdata;
      end
      if (wr_ien) begin
        ien_q <= reg_wdata[IEN_BIT];
      end
    end
  end

  // Read view; the timer is read live, so a software byte pair may straddle a carry.
  assign view[OFS_TLO]   = timer_q[7:0];                                       // [RULE6]
  assign view[OFS_THI]   = timer_q[15:8];
  assign view[OFS_CTRL]  = ctrl_q;
  assign view[OFS_FLAG]  = flag_q;
  assign view[OFS_CEDGE] = cedge_q;
  assign view[OFS_SETEN] = {tog_q, seten_q};
  assign view[OFS_RSTEN] = rsten_q;
  assign view[OFS_IEN]   = {ien_q, 7'h00};
  assign view[OFS_P4]    = p4_q;
  for (genvar u = OFS_P4 + 1; u <= OFS_LAST; u++) begin : g_unmapped
    assign view[u] = BYTE_RST;
  end

  // Read data stands in the cycle after the strobe only; interrupt is registered.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= BYTE_RST;
      irq_q   <= 1'b0;
    end else if (ce) begin
      rdata_q <= reg_rd ? view[reg_addr] : BYTE_RST;
      irq_q   <= irq_d;                                                        // [RULE11] [RULE21]
    end
  end

  assign reg_rdata = rdata_q;
  assign timer_irq = irq_q;
  assign port4     = p4_q;

endmodule
`default_nettype wire

// >>> verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import tcc_pkg::*;
;
  logic              mclk = 1'b0;
  logic              resetn = 1'b0;
  logic              idle = 1'b0;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic [DATA_W-1:0] reg_rdata;
  logic              timer_irq;
  logic [7:0]        port4;
  logic              ext_count_in;
  logic              ext_reset_in;
  logic [NCAP-1:0]   cap_in;
  logic [7:0]        v, t0, t1, seten, rsten;
  logic [13:0]       ops [5];
  int                fail_count = 0;
  int                checks_done = 0;
  int                cyc = 0;
  int                k;
  tcc_timer_capture_compare u_tcc_timer_capture_compare (.mclk, .resetn, .ce(1'b1), .idle, .ext_count_in,
    .ext_reset_in, .cap_in, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .timer_irq, .port4);
  tcc_src u_tcc_src (.mclk, .ext_count_in, .ext_reset_in, .cap_in);
  always #2.5 mclk = ~mclk;
  task automatic give_verdict();
    if (fail_count == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Bus cycles: one strobe cycle each; read data are taken in the cycle after.
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // A hang is cut short well past the few thousand cycles the sequence needs.
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      give_verdict();
    end
  end
  initial begin
    ops = '{{1'b0, OFS_FLAG, 8'h80}, {1'b1, OFS_CTRL, 8'h81}, {1'b0, OFS_IEN, 8'h00},
            {1'b1, OFS_IEN, 8'h80}, {1'b0, OFS_CTRL, 8'h01}};
    void'($urandom(99));
    tick(4);
    resetn <= 1'b1;
    rd(OFS_SETEN, v);
    cmp8(v, 8'hc0);
    wr(OFS_TLO, 8'h5a);
    rd(OFS_TLO, v);
    cmp8(v, 8'h00);
    rd(OFS_LAST, v);
    cmp8(v, 8'h00);
    // Idle holds the count at zero; each divider then gives k counts in k divided spans.
    @(posedge mclk) idle <= 1'b1;
    wr(OFS_CTRL, 8'h01);
    tick(20);
    rd(OFS_TLO, v);
    cmp8(v, 8'h00);
    @(posedge mclk) idle <= 1'b0;
    for (int p = 0; p < 4; p++) begin
      k = $urandom_range(3, 9);
      wr(OFS_CTRL, {4'h0, p[1:0], 2'h1});
      rd(OFS_TLO, t0);
      tick(6 * (1 << p) * k - 2);
      rd(OFS_TLO, t1);
      cmp8(t1 - t0, k[7:0]);
    end
    @(posedge mclk) reg_rd <= 1'b1;
    tick(4);
    reg_rd <= 1'b0;
    // External edges, thirteen clocks apart, each count once.
    wr(OFS_CTRL, 8'h02);
    rd(OFS_TLO, t0);
    k = $urandom_range(2, 8);
    u_tcc_src.count(k);
    tick(20);
    rd(OFS_TLO, t1);
    cmp8(t1 - t0, k[7:0]);
    // Byte overflow after 256 counts; the flag stays until software clears it.
    @(posedge mclk) idle <= 1'b1;
    wr(OFS_IEN, 8'h80);
    wr(OFS_CTRL, 8'h41);
    @(posedge mclk) idle <= 1'b0;
    tick(6 * 250);
    cmp1(timer_irq, 1'b0);
    tick(6 * 10);
    cmp1(timer_irq, 1'b1);
    rd(OFS_CTRL, v);
    cmp8(v, 8'h51);
    tick(60);
    cmp1(timer_irq, 1'b1);
    wr(OFS_CTRL, 8'h41);
    tick(3);
    cmp1(timer_irq, 1'b0);
    for (int i = 0; i < 5; i++) begin
      wr(ops[i][12:8], ops[i][7:0]);
      tick(3);
      cmp1(timer_irq, ops[i][13]);
    end
    wr(OFS_FLAG, 8'h00);
    // The reset pin clears the count only while enabled.
    wr(OFS_CTRL, 8'h21);
    tick(120);
    u_tcc_src.pulse_reset();
    rd(OFS_TLO, v);
    cmp1(v < 8'h03, 1'b1);
    wr(OFS_CTRL, 8'h01);
    tick(60);
    u_tcc_src.pulse_reset();
    rd(OFS_TLO, v);
    cmp1(v > 8'h08, 1'b1);
    // Every channel with rising, falling and both edges selected.
    for (int c = 0; c < 4; c++) begin
      for (int m = 1; m < 4; m++) begin
        wr(OFS_CEDGE, 8'(m << (2 * c)));
        wr(OFS_FLAG, 8'h00);
        u_tcc_src.set_cap(c, 1'b1);
        rd(OFS_FLAG, v);
        cmp1(v[c], m[0]);
        wr(OFS_FLAG, 8'h00);
        u_tcc_src.set_cap(c, 1'b0);
        rd(OFS_FLAG, v);
        cmp1(v[c], m[1]);
      end
      rd(OFS_CAP0 + 5'(2 * c), t0);
      rd(OFS_TLO, t1);
      cmp1(t1 - t0 < 8'h06, 1'b1);
    end
    // Set at 0x20, clear at 0x40 and toggle at 0x50, from random enables.
    @(posedge mclk) idle <= 1'b1;
    seten = 8'($urandom_range(0, 63));
    rsten = 8'($urandom_range(0, 255));
    wr(OFS_SETEN, seten);
    wr(OFS_RSTEN, rsten);
    wr(OFS_P4, 8'h00);
    wr(OFS_FLAG, 8'h00);
    wr(OFS_CMP0, 8'h20);
    wr(OFS_CMP0 + 5'h2, 8'h40);
    wr(OFS_CMP0 + 5'h4, 8'h50);
    @(posedge mclk) idle <= 1'b0;
    tick(6 * 40);
    cmp8(port4, seten);
    tick(6 * 30);
    cmp8(port4, seten & ~rsten & P4_SR_MASK);
    tick(6 * 20);
    cmp8(port4, (seten & ~rsten & P4_SR_MASK) | (rsten & 8'hc0));
    rd(OFS_FLAG, v);
    cmp8(v & 8'h70, 8'h70);
    rd(OFS_SETEN, v);
    cmp8(v, {~rsten[7:6], seten[5:0]});
    give_verdict();
  end
endmodule
bind tcc_timer_capture_compare tcc_chk u_tcc_chk (.mclk, .resetn, .idle, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .timer_irq, .port4);
`default_nettype wire

// >>> verification/tcc_chk.sv
`timescale 1ns/1ps
`default_nettype none
module tcc_chk
  import tcc_pkg::*;
(
  input wire logic              mclk,      // Clock.
  input wire logic              resetn,    // Reset, active low.
  input wire logic              idle,      // Idle mode.
  input wire logic [ADDR_W-1:0] reg_addr,  // Address.
  input wire logic [DATA_W-1:0] reg_wdata, // Write data.
  input wire logic              reg_wr,    // Write strobe.
  input wire logic              reg_rd,    // Read strobe.
  input wire logic [DATA_W-1:0] reg_rdata, // Read data.
  input wire logic              timer_irq, // Interrupt.
  input wire logic [7:0]        port4      // Port latch.
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // Phase count; the clock enable is held high, so the cycle ends every sixth edge.
  logic [2:0] ph_q;
  logic [2:0] ph_d;
  assign ph_d = (ph_q == 3'h5) ? 3'h0 : ph_q + 3'h1;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn)
      ph_q <= 3'h0;
    else
      ph_q <= ph_d;
  end
  sequence s_idle_rd;
    idle [*3] ##0 (reg_rd && reg_addr[4:1] == 4'h0);
  endsequence
  sequence s_rd_pair;
    (reg_rd && reg_addr == OFS_TLO && ph_q != 3'h5) ##1 (reg_rd && reg_addr == OFS_TLO);
  endsequence
  AST_RD_ONE: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data outside its slot");
  AST_CYCLE_STEP: assert property (
    s_rd_pair |=> reg_rdata == $past(reg_rdata)) else $error("timer moved inside a cycle");
  AST_IDLE_ZERO: assert property (
    s_idle_rd |=> reg_rdata == 8'h00) else $error("timer not held in idle");
  AST_CTRL_MASK: assert property (
    reg_wr && reg_addr == OFS_CTRL && reg_wdata[7:6] == 2'h0 |-> ##2 !timer_irq)
    else $error("request without select");
  AST_IEN_MASK: assert property (
    reg_wr && reg_addr == OFS_IEN && !reg_wdata[IEN_BIT] |-> ##2 !timer_irq)
    else $error("request without enable");
  AST_FLAG_STICKY: assert property (
    $fell(timer_irq) |-> $past(reg_wr, 2)) else $error("request dropped by itself");
  AST_RESET_QUIET: assert property (disable iff (1'b0)
    $rose(resetn) |-> port4 == 8'h00 && !timer_irq) else $error("outputs not cleared");
  AST_P4_CYCLE: assert property (
    $changed(port4) |-> $past(ph_q) == 3'h5 || $past(reg_wr && reg_addr == OFS_P4))
    else $error("port changed off cycle end");
endmodule
`default_nettype wire

// >>> verification/tcc_src.sv
`timescale 1ns/1ps
`default_nettype none
// Outside sources of count, timer reset and capture levels, all moved just after an edge.
module tcc_src
  import tcc_pkg::*;
(
  input  wire logic            mclk,         // Clock.
  output logic                 ext_count_in, // Count pin.
  output logic                 ext_reset_in, // Reset pin.
  output logic      [NCAP-1:0] cap_in        // Capture pins.
);
  initial begin
    ext_count_in = 1'b0;
    ext_reset_in = 1'b0;
    cap_in = '0;
  end
  // Each level stands a whole machine cycle, twice what the sampler needs to see it.
  task count(input int n);
    repeat (n) begin
      @(posedge mclk) ext_count_in <= 1'b1;
      repeat (6) @(posedge mclk);
      ext_count_in <= 1'b0;
      repeat (6) @(posedge mclk);
    end
  endtask
  // A short high pulse; only its rising edge matters.
  task pulse_reset();
    @(posedge mclk) ext_reset_in <= 1'b1;
    repeat (6) @(posedge mclk);
    ext_reset_in <= 1'b0;
  endtask
  // Two machine cycles pass so the level is seen at a first phase and captured.
  task set_cap(input int c, input logic v);
    @(posedge mclk) cap_in[c] <= v;
    repeat (12) @(posedge mclk);
  endtask
endmodule
`default_nettype wire
